// ---- tb/cte_core_bench.sv ----
// self-checking bench of the transfer/arithmetic executor
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module cte_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, busy, ill, m_we = 1'h0;
  logic [7:0]  adr = 8'h00, m_adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, m_dat = 32'h0, m_q, q;
  int          fail_count = 0, num_checks = 0, ticks = 0;
  always #12.5 clk_i = ~clk_i;
  cte_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy), .illegal_o(ill));
  cte_stack_model stk (.clk_i(clk_i), .we_i(m_we), .adr_i(m_adr), .dat_i(m_dat), .dat_o(m_q));
  function automatic logic [7:0] ga(input logic [2:0] n);
    return {3'h1, n, 2'h0};
  endfunction : ga
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (ack !== 1'h1);
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'h0, a, 32'h0);
    `CHK(n, e, q)
  endtask : rc
  // poll status instead of trusting a fixed latency per command kind
  task automatic run(input logic [31:0] c);
    wb(1'h1, 8'h00, c);
    do wb(1'h0, 8'h08, 32'h0); while (q[0] !== 1'h0);
  endtask : run
  task automatic mset(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {m_we, m_adr, m_dat} <= {1'h1, a, d};
    @(posedge clk_i);
    m_we <= 1'h0;
  endtask : mset
  task automatic t_xfer;
    rc(8'h0c, 32'h0, "ccr rst");
    wb(1'h1, ga(1), 32'h89ab_cdef);
    run(32'h0002_1040);
    rc(ga(2), 32'h89ab_cdef, "long");
    run(32'h000b_9000);
    rc(ga(3), 32'h0000_00ef, "byte");
    wb(1'h1, 8'h04, 32'h0000_1234);
    run(32'h000c_0120);
    rc(ga(4), 32'h1234_0000, "upper");
  endtask : t_xfer
  task automatic t_arith;
    wb(1'h1, ga(5), 32'h0000_7fff);
    wb(1'h1, 8'h04, 32'h0000_0001);
    run(32'h0005_0127);
    rc(ga(5), 32'h0000_8000, "sum");
    rc(8'h0c, 32'h0000_000a, "flags");
    wb(1'h1, 8'h0c, 32'h0000_0001);
    run(32'h000d_9009);
    rc(ga(5), 32'h0000_80f0, "carry");
    rc(8'h0c, 32'h0000_0008, "carry flags");
    run(32'h0015_002b);
    rc(ga(5), 32'h0000_80f2, "step");
    run(32'h0025_004e);
    rc(ga(5), 32'h0000_80ee, "ptr");
  endtask : t_arith
  task automatic t_illegal;
    logic [31:0] bad [5];
    bad = '{32'h0000_0001, 32'h0000_0002, 32'h000d_0108, 32'h001d_000b, 32'h0088_0a00};
    foreach (bad[i]) begin
      run(bad[i]);
      rc(8'h08, 32'h0000_0002, "refused");
      rc(ga(5), 32'h0000_80ee, "kept");
    end
    run(32'h0000_0000);
    rc(8'h08, 32'h0000_0000, "cleared");
  endtask : t_illegal
  task automatic t_stack;
    wb(1'h1, ga(7), 32'h0000_0100);
    run(32'h0000_1344);
    rc(ga(7), 32'h0000_00fc, "sp put");
    run(32'h0006_0243);
    rc(ga(6), 32'h89ab_cdef, "pop");
    rc(ga(7), 32'h0000_0100, "sp get");
  endtask : t_stack
  task automatic t_multi;
    wb(1'h1, ga(2), 32'h5a5a_0002);
    run(32'h0002_1346);
    mset(8'hfc, 32'h89ab_cdef);
    mset(8'hf8, 32'h5a5a_0002);
    rc(ga(7), 32'h0000_00f8, "sp list");
    run(32'h0006_5245);
    rc(ga(6), m_q, "list hi");
    rc(ga(5), 32'h89ab_cdef, "list lo");
    rc(ga(7), 32'h0000_0100, "sp back");
  endtask : t_multi
  // store through a negative 16-bit displacement, read one byte back by 16-bit absolute
  task automatic t_mem;
    wb(1'h1, 8'h04, 32'h0000_fff0);
    run(32'h0047_1740);
    wb(1'h1, 8'h04, 32'h0000_00f1);
    run(32'h0048_0a00);
    rc(ga(0), 32'h0000_00ab, "disp abs");
  endtask : t_mem
  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    t_xfer();
    t_arith();
    t_illegal();
    t_stack();
    t_multi();
    t_mem();
    end_sim();
  end
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      fail_count++;
      end_sim();
    end
  end
endmodule : cte_core_bench

// ---- tb/cte_core_properties.sv ----
// port assertions of the transfer/arithmetic executor
module cte_core_properties #(
  parameter int unsigned MEM_AW = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        busy_o,
  input wire logic        illegal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_cmd;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && !busy_o;
  endsequence
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_busy_start; s_cmd ##1 wb_ack_o |=> busy_o; endproperty
  a_busy_start: assert property (p_busy_start) else $error("command not started");
  property p_busy_end; $rose(busy_o) |-> ##[1:12] !busy_o; endproperty
  a_busy_end: assert property (p_busy_end) else $error("command hangs");
  property p_psync; s_cmd ##0 (wb_dat_i[4:0] inside {5'h01, 5'h02}) ##1 wb_ack_o |-> ##[1:3] illegal_o; endproperty
  a_psync: assert property (p_psync) else $error("sync transfer ran");
  property p_ill_clr; s_cmd ##0 (wb_dat_i == 32'h0000_0000) ##1 wb_ack_o |-> ##[1:3] !illegal_o; endproperty
  a_ill_clr: assert property (p_ill_clr) else $error("refusal stuck");
  property p_rst; @(posedge clk_i) disable iff (1'b0) rst_i |=> !wb_ack_o && !busy_o && !illegal_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : cte_core_properties

bind cte_core cte_core_properties #(.MEM_AW(MEM_AW)) u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .illegal_o(illegal_o));

// ---- tb/cte_stack_model.sv ----
// image of the stack words the executor should leave in memory
module cte_stack_model (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem_q [0:63];
  // word grain only: byte stack slots never exist
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[adr_i[7:2]] <= dat_i;
    end
  end
  assign dat_o = mem_q[adr_i[7:2]];
endmodule : cte_stack_model

// ---- verilog/cte_core.sv ----
// executor of data-transfer and basic arithmetic commands with wishbone register access
//
// Operation
// - a transfer copies a byte, word or longword between registers, between register and memory, or from an immediate.
// - peripheral-synchronised byte load and store are refused as illegal.
// - the stack retrieve reads at the stack pointer and then advances it, exactly as a post-increment load through it.
// - the stack store first lowers the stack pointer and then writes there, exactly as a pre-decrement store.
// - the multi-register retrieve restores a list of two to four registers from the stack as longwords.
// - the multi-register store saves a list of two to four registers as longwords, lowering the pointer before each.
// - sum and difference combine two registers or an immediate and a register at any size into the destination.
// - the difference refuses a byte-size immediate operand.
// - carry-add and borrow-subtract work on bytes only and fold the current carry into the result.
// - step-up and step-down add or subtract 1 or 2 to a register at any size.
// - a byte step-up or step-down may only step by one.
// - pointer adjust adds or subtracts 1, 2 or 4 to a whole 32-bit register, longword only.
// - eight 32-bit registers, each split in two 16-bit halves, the lower half in a high and a low byte.
// - the condition register holds negative, zero, overflow and carry, set by results and used by carry ops.
// - displacement fields are accepted at 16 or 32 bits, absolute fields at 16 or 32 bits or at 8 bits for byte size only.
`include "cte_defines.svh"

module cte_core
  import cte_pkg::*;
#(
  parameter int unsigned MEM_AW = `CTE_MEM_AW
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy_o,
  output logic             illegal_o
);

  localparam cte_core_t CORE_RST = '{st: CTE_ST_IDLE, cond_flags_reg: `CTE_CCR_RST, default: '0};

  cte_core_t    q;
  cte_core_t    n;
  cte_mem_req_t mreq;
  logic [31:0]  mem_rdata;

  // register views by size; for sub-long sizes bit 3 of the index picks upper half / low byte
  function automatic logic [31:0] gr_get(logic [7:0][31:0] gr, logic [3:0] r, cte_size_t sz);
    case (sz)
      CTE_SZ_B: gr_get = {24'h0, r[3] ? gr[r[2:0]][7:0] : gr[r[2:0]][15:8]};
      CTE_SZ_W: gr_get = {16'h0, r[3] ? gr[r[2:0]][31:16] : gr[r[2:0]][15:0]};
      default:  gr_get = gr[r[2:0]];
    endcase
  endfunction : gr_get

  function automatic logic [31:0] gr_put(logic [31:0] old, logic [3:0] r, cte_size_t sz, logic [31:0] v);
    gr_put = old;
    case (sz)
      CTE_SZ_B: begin
        if (r[3]) begin
          gr_put[7:0] = v[7:0];
        end else begin
          gr_put[15:8] = v[7:0];
        end
      end
      CTE_SZ_W: begin
        if (r[3]) begin
          gr_put[31:16] = v[15:0];
        end else begin
          gr_put[15:0] = v[15:0];
        end
      end
      default: gr_put = v;
    endcase
  endfunction : gr_put

  function automatic logic [4:0] sz_sh(cte_size_t sz);
    case (sz)
      CTE_SZ_B: sz_sh = `CTE_SH_B;
      CTE_SZ_W: sz_sh = `CTE_SH_W;
      default:  sz_sh = `CTE_SH_L;
    endcase
  endfunction : sz_sh

  function automatic logic [31:0] sz_bytes(cte_size_t sz);
    case (sz)
      CTE_SZ_B: sz_bytes = `CTE_BYTES_B;
      CTE_SZ_W: sz_bytes = `CTE_BYTES_W;
      default:  sz_bytes = `CTE_BYTES_L;
    endcase
  endfunction : sz_bytes

  // operands are aligned to bit 31 so one adder gives carry and overflow for every size
  function automatic logic [35:0] alu(logic [31:0] a, logic [31:0] b, logic cin, logic sub, cte_size_t sz);
    logic [4:0]  sh;
    logic [31:0] as;
    logic [31:0] bs;
    logic [31:0] cs;
    logic [32:0] s;
    logic        v;
    sh = sz_sh(sz);
    as = a << sh;
    bs = b << sh;
    cs = {31'h0, cin} << sh;
    s  = sub ? ({1'b0, as} - {1'b0, bs} - {1'b0, cs}) : ({1'b0, as} + {1'b0, bs} + {1'b0, cs});
    v  = sub ? ((as[31] ^ bs[31]) & (as[31] ^ s[31])) : (~(as[31] ^ bs[31]) & (as[31] ^ s[31]));
    alu = {s[31], s[31:0] == 32'h0, v, s[32], s[31:0] >> sh};
  endfunction : alu

  function automatic logic [1:0] nz_of(logic [31:0] v, cte_size_t sz);
    logic [31:0] w;
    w = v << sz_sh(sz);
    nz_of = {w[31], w == 32'h0};
  endfunction : nz_of

  // absolute :8 lands in the top page, :24 is zero-extended, displacements are signed
  function automatic logic [31:0] ext_field(logic [31:0] f, logic [1:0] len, logic is_abs);
    case (len)
      `CTE_LEN_8:  ext_field = is_abs ? {24'hff_ffff, f[7:0]} : {{24{f[7]}}, f[7:0]};
      `CTE_LEN_16: ext_field = {{16{f[15]}}, f[15:0]};
      `CTE_LEN_24: ext_field = is_abs ? {8'h00, f[23:0]} : {{8{f[23]}}, f[23:0]};
      default:     ext_field = f;
    endcase
  endfunction : ext_field

  function automatic logic reg_ok(logic [3:0] r, cte_size_t sz);
    reg_ok = (sz == CTE_SZ_L) ? !r[3] : (sz == CTE_SZ_B || sz == CTE_SZ_W);
  endfunction : reg_ok

  function automatic logic am_ok(cte_cmd_t c);
    case (c.am)
      CTE_AM_DISP: am_ok = (c.len == `CTE_LEN_16) || (c.len == `CTE_LEN_32);
      CTE_AM_ABS:  am_ok = (c.len == `CTE_LEN_16) || (c.len == `CTE_LEN_32) ||
                           (c.len == `CTE_LEN_8 && c.sz == CTE_SZ_B);
      default:     am_ok = 1'b1;
    endcase
  endfunction : am_ok

  function automatic logic cmd_legal(cte_cmd_t c);
    logic two_op;
    two_op = (c.mode == CTE_MD_REG) ? reg_ok(c.rs, c.sz) && reg_ok(c.rd, c.sz)
                                    : (c.mode == CTE_MD_IMM) && reg_ok(c.rd, c.sz);
    case (c.op)
      CTE_OP_TRANSFER: begin
        case (c.mode)
          CTE_MD_LOAD:  cmd_legal = reg_ok(c.rd, c.sz) && am_ok(c);
          CTE_MD_STORE: cmd_legal = reg_ok(c.rs, c.sz) && am_ok(c);
          default:      cmd_legal = two_op;
        endcase
      end
      CTE_OP_PSYNC_LOAD, CTE_OP_PSYNC_STORE: cmd_legal = 1'b0;
      CTE_OP_STK_GET: cmd_legal = (c.sz != CTE_SZ_B) && reg_ok(c.rd, c.sz);
      CTE_OP_STK_PUT: cmd_legal = (c.sz != CTE_SZ_B) && reg_ok(c.rs, c.sz);
      CTE_OP_MULTI_GET, CTE_OP_MULTI_PUT: begin
        cmd_legal = (c.sz == CTE_SZ_L) && !c.rs[3] && !c.rd[3] && (c.rd[2:0] > c.rs[2:0]) &&
                    ((c.rd[2:0] - c.rs[2:0]) <= `CTE_LIST_SPAN);
      end
      CTE_OP_SUM:  cmd_legal = two_op;
      CTE_OP_DIFF: cmd_legal = two_op && !(c.mode == CTE_MD_IMM && c.sz == CTE_SZ_B);
      CTE_OP_SUM_CARRY, CTE_OP_DIFF_BORROW: cmd_legal = two_op && (c.sz == CTE_SZ_B);
      CTE_OP_STEP_UP, CTE_OP_STEP_DOWN: begin
        cmd_legal = (c.mode == CTE_MD_REG) && reg_ok(c.rd, c.sz) && (c.step <= `CTE_STEP_TWO) &&
                    !(c.step == `CTE_STEP_TWO && c.sz == CTE_SZ_B);
      end
      CTE_OP_PTR_PLUS, CTE_OP_PTR_MINUS: begin
        cmd_legal = (c.sz == CTE_SZ_L) && (c.mode == CTE_MD_REG) && !c.rd[3] &&
                    (c.step <= `CTE_PTR_MAX);
      end
      default: cmd_legal = 1'b0;
    endcase
  endfunction : cmd_legal

  // big-endian lanes: lowest byte address sits in bits 31:24
  function automatic logic [31:0] lane_get(logic [31:0] w, logic [1:0] a, cte_size_t sz);
    case (sz)
      CTE_SZ_B: lane_get = (w >> {~a, 3'b000}) & 32'h0000_00ff;
      CTE_SZ_W: lane_get = {16'h0, a[1] ? w[15:0] : w[31:16]};
      default:  lane_get = w;
    endcase
  endfunction : lane_get

  function automatic logic [3:0] lane_be(logic [1:0] a, cte_size_t sz);
    case (sz)
      CTE_SZ_B: lane_be = 4'b1000 >> a;
      CTE_SZ_W: lane_be = a[1] ? 4'b0011 : 4'b1100;
      default:  lane_be = 4'b1111;
    endcase
  endfunction : lane_be

  function automatic logic [31:0] lane_data(logic [31:0] v, cte_size_t sz);
    case (sz)
      CTE_SZ_B: lane_data = {4{v[7:0]}};
      CTE_SZ_W: lane_data = {2{v[15:0]}};
      default:  lane_data = v;
    endcase
  endfunction : lane_data

  function automatic logic [31:0] sel_merge(logic [31:0] old, logic [31:0] w, logic [3:0] sel);
    sel_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        sel_merge[8*i +: 8] = w[8*i +: 8];
      end
    end
  endfunction : sel_merge

  always_comb begin
    cte_cmd_t    c;
    logic [31:0] v;
    logic [31:0] base;
    logic [31:0] ea;
    logic [31:0] sp;
    logic [35:0] r;
    logic [1:0]  f;
    logic        sub;
    c    = q.cmd;
    v    = 32'h0;
    base = 32'h0;
    ea   = 32'h0;
    sp   = q.gr[`CTE_SP_IDX];
    r    = 36'h0;
    f    = 2'h0;
    sub  = 1'b0;
    n    = q;
    mreq = '0;

    n.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    n.dat = 32'h0;
    if (n.ack) begin
      if (wb_adr_i[7:5] == `CTE_GR_PAGE && wb_adr_i[1:0] == 2'h0) begin
        n.dat = q.gr[wb_adr_i[4:2]];
      end else begin
        case (wb_adr_i)
          `CTE_OFF_CMD:  n.dat = q.cmd;
          `CTE_OFF_IMM:  n.dat = q.imm;
          `CTE_OFF_STAT: n.dat = {30'h0, q.err, q.st != CTE_ST_IDLE};
          `CTE_OFF_CCR:  n.dat = {28'h0, q.cond_flags_reg};
          default:       n.dat = 32'h0;
        endcase
      end
    end

    case (q.st)
      CTE_ST_IDLE: begin
        // software writes only land while idle, so they never race the executor
        if (wb_cyc_i && wb_stb_i && wb_we_i && q.ack) begin
          if (wb_adr_i[7:5] == `CTE_GR_PAGE && wb_adr_i[1:0] == 2'h0) begin
            n.gr[wb_adr_i[4:2]] = sel_merge(q.gr[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
          end else begin
            case (wb_adr_i)
              `CTE_OFF_CMD: begin
                n.cmd = cte_cmd_t'(sel_merge(q.cmd, wb_dat_i, wb_sel_i));
                n.err = 1'b0;
                n.st  = CTE_ST_EXEC;
              end
              `CTE_OFF_IMM: n.imm = sel_merge(q.imm, wb_dat_i, wb_sel_i);
              `CTE_OFF_CCR: n.cond_flags_reg = wb_sel_i[0] ? cte_ccr_t'(wb_dat_i[3:0]) : q.cond_flags_reg;
              default: ;
            endcase
          end
        end
      end

      CTE_ST_EXEC: begin
        n.st = CTE_ST_IDLE;
        if (!cmd_legal(q.cmd)) begin
          n.err = 1'b1;
        end else begin
          if (q.cmd.op == CTE_OP_STK_GET) begin
            c.op = CTE_OP_TRANSFER;
            c.mode = CTE_MD_LOAD;
            c.am = CTE_AM_AUTO;
            c.rs = {1'b0, `CTE_SP_IDX};
          end else if (q.cmd.op == CTE_OP_STK_PUT) begin
            c.op = CTE_OP_TRANSFER;
            c.mode = CTE_MD_STORE;
            c.am = CTE_AM_AUTO;
            c.rd = {1'b0, `CTE_SP_IDX};
          end
          n.cmd = c;
          base = q.gr[(c.mode == CTE_MD_LOAD) ? c.rs[2:0] : c.rd[2:0]];
          case (c.am)
            CTE_AM_DISP: ea = base + ext_field(q.imm, c.len, 1'b0);
            CTE_AM_ABS:  ea = ext_field(q.imm, c.len, 1'b1);
            CTE_AM_AUTO: ea = (c.mode == CTE_MD_STORE) ? base - sz_bytes(c.sz) : base;
            default:     ea = base;
          endcase
          sub = (c.op == CTE_OP_DIFF) || (c.op == CTE_OP_DIFF_BORROW) ||
                (c.op == CTE_OP_STEP_DOWN) || (c.op == CTE_OP_PTR_MINUS);
          v = (c.mode == CTE_MD_IMM) ? q.imm : gr_get(q.gr, c.rs, c.sz);
          case (c.op)
            CTE_OP_TRANSFER: begin
              case (c.mode)
                CTE_MD_LOAD: begin
                  mreq.addr = ea;
                  n.addr = ea[1:0];
                  if (c.am == CTE_AM_AUTO) begin
                    n.gr[c.rs[2:0]] = base + sz_bytes(c.sz);
                  end
                  n.st = CTE_ST_LOAD;
                end
                CTE_MD_STORE: begin
                  mreq = '{we: 1'b1, be: lane_be(ea[1:0], c.sz), addr: ea, wdata: lane_data(v, c.sz)};
                  if (c.am == CTE_AM_AUTO) begin
                    n.gr[c.rd[2:0]] = ea;
                  end
                  f = nz_of(v, c.sz);
                  n.cond_flags_reg = '{n: f[1], z: f[0], v: 1'b0, c: q.cond_flags_reg.c};
                end
                default: begin
                  n.gr[c.rd[2:0]] = gr_put(q.gr[c.rd[2:0]], c.rd, c.sz, v);
                  f = nz_of(v, c.sz);
                  n.cond_flags_reg = '{n: f[1], z: f[0], v: 1'b0, c: q.cond_flags_reg.c};
                end
              endcase
            end
            CTE_OP_MULTI_GET: begin
              n.idx = c.rd[2:0];
              n.st = CTE_ST_MULTI;
            end
            CTE_OP_MULTI_PUT: begin
              n.idx = c.rs[2:0];
              n.st = CTE_ST_MULTI;
            end
            CTE_OP_SUM, CTE_OP_DIFF, CTE_OP_SUM_CARRY, CTE_OP_DIFF_BORROW: begin
              r = alu(gr_get(q.gr, c.rd, c.sz), v, (c.op == CTE_OP_SUM_CARRY || c.op == CTE_OP_DIFF_BORROW) &&
                      q.cond_flags_reg.c, sub, c.sz);
              n.gr[c.rd[2:0]] = gr_put(q.gr[c.rd[2:0]], c.rd, c.sz, r[31:0]);
              n.cond_flags_reg = cte_ccr_t'(r[35:32]);
              if (c.op == CTE_OP_SUM_CARRY || c.op == CTE_OP_DIFF_BORROW) begin
                n.cond_flags_reg.z = q.cond_flags_reg.z & r[34];
              end
            end
            CTE_OP_STEP_UP, CTE_OP_STEP_DOWN: begin
              r = alu(gr_get(q.gr, c.rd, c.sz), (c.step == `CTE_STEP_TWO) ? `CTE_BYTES_W : `CTE_BYTES_B,
                      1'b0, sub, c.sz);
              n.gr[c.rd[2:0]] = gr_put(q.gr[c.rd[2:0]], c.rd, c.sz, r[31:0]);
              n.cond_flags_reg = '{n: r[35], z: r[34], v: r[33], c: q.cond_flags_reg.c};
            end
            CTE_OP_PTR_PLUS, CTE_OP_PTR_MINUS: begin
              v = 32'h1 << c.step;
              n.gr[c.rd[2:0]] = sub ? q.gr[c.rd[2:0]] - v : q.gr[c.rd[2:0]] + v;
            end
            default: n.err = 1'b1;
          endcase
        end
      end

      CTE_ST_MULTI: begin
        if (q.cmd.op == CTE_OP_MULTI_PUT) begin
          sp = q.gr[`CTE_SP_IDX] - `CTE_BYTES_L;
          mreq = '{we: 1'b1, be: 4'b1111, addr: sp, wdata: q.gr[q.idx]};
          n.gr[`CTE_SP_IDX] = sp;
          n.idx = q.idx + 3'h1;
          n.st = (q.idx == q.cmd.rd[2:0]) ? CTE_ST_IDLE : CTE_ST_MULTI;
        end else begin
          mreq.addr = sp;
          n.addr = sp[1:0];
          n.st = CTE_ST_LOAD;
        end
      end

      CTE_ST_LOAD: begin
        n.st = CTE_ST_IDLE;
        if (q.cmd.op == CTE_OP_MULTI_GET) begin
          // pointer moves first so a loaded stack pointer keeps the memory value
          n.gr[`CTE_SP_IDX] = q.gr[`CTE_SP_IDX] + `CTE_BYTES_L;
          n.gr[q.idx] = mem_rdata;
          n.idx = q.idx - 3'h1;
          n.st = (q.idx == q.cmd.rs[2:0]) ? CTE_ST_IDLE : CTE_ST_MULTI;
        end else begin
          v = lane_get(mem_rdata, q.addr, q.cmd.sz);
          n.gr[q.cmd.rd[2:0]] = gr_put(q.gr[q.cmd.rd[2:0]], q.cmd.rd, q.cmd.sz, v);
          f = nz_of(v, q.cmd.sz);
          n.cond_flags_reg = '{n: f[1], z: f[0], v: 1'b0, c: q.cond_flags_reg.c};
        end
      end

      default: n.st = CTE_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= CORE_RST;
    end else begin
      q <= n;
    end
  end

  cte_data_mem #(
    .AW (MEM_AW)
  ) u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .req_i   (mreq),
    .rdata_o (mem_rdata)
  );

  assign wb_dat_o  = q.dat;
  assign wb_ack_o  = q.ack;
  assign busy_o    = (q.st != CTE_ST_IDLE);
  assign illegal_o = q.err;

endmodule : cte_core

// ---- verilog/cte_data_mem.sv ----
// byte-lane data memory seen by the executor, registered read data
module cte_data_mem
  import cte_pkg::*;
#(
  parameter int unsigned AW = `CTE_MEM_AW
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire cte_mem_req_t req_i,
  output logic [31:0]       rdata_o
);

  logic [31:0] mem_q [2**AW];

  // array is not reset; only the read port is
  always_ff @(posedge clk_i) begin
    if (req_i.we) begin
      for (int i = 0; i < 4; i++) begin
        if (req_i.be[i]) begin
          mem_q[req_i.addr[AW+1:2]][8*i +: 8] <= req_i.wdata[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= `CTE_RDATA_RST;
    end else begin
      rdata_o <= mem_q[req_i.addr[AW+1:2]];
    end
  end

endmodule : cte_data_mem

// ---- verilog/cte_defines.svh ----
// register offsets, reset values and small constants of the transfer/arithmetic executor
`ifndef CTE_DEFINES_SVH
`define CTE_DEFINES_SVH

// wishbone register byte offsets
`define CTE_OFF_CMD      8'h00
`define CTE_OFF_IMM      8'h04
`define CTE_OFF_STAT     8'h08
`define CTE_OFF_CCR      8'h0c
`define CTE_GR_PAGE      3'h1
// status bit positions
`define CTE_STAT_BUSY    0
`define CTE_STAT_ERR     1
// reset values
`define CTE_CCR_RST      4'h0
`define CTE_RDATA_RST    32'h0000_0000
// stack pointer register index
`define CTE_SP_IDX       3'h7
// byte counts per operand size and per multi-register slot
`define CTE_BYTES_B      32'h0000_0001
`define CTE_BYTES_W      32'h0000_0002
`define CTE_BYTES_L      32'h0000_0004
// operand alignment shifts that put the sign bit at bit 31
`define CTE_SH_B         5'd24
`define CTE_SH_W         5'd16
`define CTE_SH_L         5'd0
// limits of the register list and small constants
`define CTE_LIST_SPAN    3'h3
`define CTE_STEP_TWO     2'h1
`define CTE_PTR_MAX      2'h2
// displacement and absolute field lengths
`define CTE_LEN_8        2'h0
`define CTE_LEN_16       2'h1
`define CTE_LEN_24       2'h2
`define CTE_LEN_32       2'h3
// memory size in address bits of 32-bit words
`define CTE_MEM_AW       8

`endif

// ---- verilog/cte_pkg.sv ----
// types shared by the transfer/arithmetic executor and its data memory
package cte_pkg;

  typedef enum logic [4:0] {
    CTE_OP_TRANSFER    = 5'h00,
    CTE_OP_PSYNC_LOAD  = 5'h01,
    CTE_OP_PSYNC_STORE = 5'h02,
    CTE_OP_STK_GET     = 5'h03,
    CTE_OP_STK_PUT     = 5'h04,
    CTE_OP_MULTI_GET   = 5'h05,
    CTE_OP_MULTI_PUT   = 5'h06,
    CTE_OP_SUM         = 5'h07,
    CTE_OP_DIFF        = 5'h08,
    CTE_OP_SUM_CARRY   = 5'h09,
    CTE_OP_DIFF_BORROW = 5'h0a,
    CTE_OP_STEP_UP     = 5'h0b,
    CTE_OP_STEP_DOWN   = 5'h0c,
    CTE_OP_PTR_PLUS    = 5'h0d,
    CTE_OP_PTR_MINUS   = 5'h0e
  } cte_op_t;

  typedef enum logic [1:0] {
    CTE_SZ_B = 2'h0,
    CTE_SZ_W = 2'h1,
    CTE_SZ_L = 2'h2
  } cte_size_t;

  typedef enum logic [1:0] {
    CTE_MD_REG   = 2'h0,
    CTE_MD_IMM   = 2'h1,
    CTE_MD_LOAD  = 2'h2,
    CTE_MD_STORE = 2'h3
  } cte_mode_t;

  typedef enum logic [1:0] {
    CTE_AM_IND  = 2'h0,
    CTE_AM_DISP = 2'h1,
    CTE_AM_ABS  = 2'h2,
    CTE_AM_AUTO = 2'h3
  } cte_am_t;

  typedef enum logic [3:0] {
    CTE_ST_IDLE  = 4'b0001,
    CTE_ST_EXEC  = 4'b0010,
    CTE_ST_LOAD  = 4'b0100,
    CTE_ST_MULTI = 4'b1000
  } cte_state_t;

  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [1:0] len;
    logic [1:0] step;
    logic [3:0] rd;
    logic [3:0] rs;
    cte_am_t    am;
    cte_mode_t  mode;
    logic       rsvd_lo;
    cte_size_t  sz;
    cte_op_t    op;
  } cte_cmd_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cte_ccr_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cte_mem_req_t;

  typedef struct packed {
    cte_state_t       st;
    cte_cmd_t         cmd;
    logic [31:0]      imm;
    logic [7:0][31:0] gr;
    cte_ccr_t         cond_flags_reg;
    logic             err;
    logic [2:0]       idx;
    logic [1:0]       addr;
    logic             ack;
    logic [31:0]      dat;
  } cte_core_t;

endpackage : cte_pkg
